/* File: hw/ffgc_device.sv */
// The implementer's own choices: the address map and register access over AHB-Lite.
`timescale 1ns/10ps
// Operation
// R1 - collect sixteen lines after generate, then compute
// R2 - partner supplies sixteen triggers or waits free-run
// R3 - line and data valid keep toggling during calibration
// R4 - no command acknowledge while calibration runs
// R5 - partner holds commands until generation completes
// R6 - average each pixel over sixteen lines
// R7 - brightest average pixel is the reference
// R8 - gain per pixel raises average to reference
// R9 - new table replaces old in volatile memory
// R10 - enabled gain multiplies each outgoing pixel
// R11 - offset enable selects corrected averaging input
// R12 - generate field write starts calibration collection
// R13 - mode field write switches gain correction
// R14 - tables cover every sensor pixel, any area
// R15 - enabled offset adds stored per-pixel offset
// R16 - volatile tables lost at reset
// R17 - old table used until swap at line boundary
module ffgc_device #(
    parameter int LINE_PIX = ffgc_pkg::LINE_PIX_DEF,
    parameter int FREE_CYC = ffgc_pkg::FREE_RUN_CYC,
    parameter int IDX_W    = $clog2(LINE_PIX)
) (
    // clock and reset
    input  logic                       hclk,
    input  logic                       hresetn,
    // link to the frame grabber
    ffgc_if.dev                        lnk,
    // sensor side
    output logic                       capture_req,
    input  logic                       sens_valid,
    input  logic [ffgc_pkg::PIX_W-1:0] sens_data,
    // dark offset table load
    input  logic                       ofs_we,
    input  logic [IDX_W-1:0]           ofs_addr,
    input  logic [ffgc_pkg::PIX_W-1:0] ofs_data
);
    localparam int PW  = ffgc_pkg::PIX_W;
    localparam int GW  = ffgc_pkg::GAIN_W;
    localparam int AW  = ffgc_pkg::ACC_W;
    localparam int SW  = ffgc_pkg::CAL_SHIFT;
    localparam int PRW = PW + GW;
    localparam int FCW = $clog2(FREE_CYC + 1);
    localparam logic [IDX_W-1:0] LAST_IDX = IDX_W'(LINE_PIX - 1);

    // ------------------------------------------------------------------
    // volatile tables: contents are not reset, tab_valid guards use of the gain table
    // ------------------------------------------------------------------
    logic [PW-1:0] ofs_tab  [0:LINE_PIX-1];
    logic [GW-1:0] gain_tab [0:1][0:LINE_PIX-1];
    logic [AW-1:0] acc      [0:LINE_PIX-1];

    ffgc_pkg::ffgc_state_e       st;
    ffgc_pkg::ffgc_state_e       next_st;
    logic [ffgc_pkg::MODE_W-1:0] mode;
    logic                        bank;
    logic                        tab_valid;
    logic [IDX_W-1:0]            idx;
    logic [IDX_W-1:0]            sidx;
    logic [SW-1:0]               line_cnt;
    logic [PW-1:0]               ref_avg;
    logic [FCW-1:0]              free_cnt;
    logic                        div_done;
    logic [GW-1:0]               div_q;

    // ------------------------------------------------------------------
    // command decode
    // ------------------------------------------------------------------
    wire cmd_take = lnk.cmd_valid && (st == ffgc_pkg::S_IDLE);
    wire mode_cmd = cmd_take && (lnk.cmd_sel == ffgc_pkg::SEL_MODE);
    wire gen_cmd  = cmd_take && (lnk.cmd_sel == ffgc_pkg::SEL_GEN)
                    && lnk.cmd_data[ffgc_pkg::GEN_BIT];
    wire gain_en  = mode[ffgc_pkg::MODE_GAIN_BIT];
    wire ofs_en   = mode[ffgc_pkg::MODE_OFS_BIT];
    wire free_run = mode[ffgc_pkg::MODE_FREE_BIT];

    assign lnk.cmd_ack  = cmd_take; // R4
    assign lnk.cal_busy = (st != ffgc_pkg::S_IDLE);

    // ------------------------------------------------------------------
    // line timing: external trigger or internal free-run period
    // ------------------------------------------------------------------
    wire free_tick = free_run && (free_cnt == FCW'(FREE_CYC - 1));
    wire trig_tick = free_run ? free_tick : lnk.line_trig; // R2

    // ------------------------------------------------------------------
    // pixel path: offset then gain, with saturation
    // ------------------------------------------------------------------
    wire           last_pix = sens_valid && (idx == LAST_IDX);
    wire [PW:0]    ofs_sum  = {1'b0, sens_data} + {1'b0, ofs_tab[idx]};
    wire [PW-1:0]  ofs_pix  = ofs_sum[PW] ? {PW{1'b1}} : ofs_sum[PW-1:0];
    wire [PW-1:0]  pix_c    = ofs_en ? ofs_pix : sens_data; // R15 R11
    wire [GW-1:0]  gain_cur = tab_valid ? gain_tab[bank][idx] : ffgc_pkg::GAIN_ONE; // R16
    wire [PRW-1:0] prod     = PRW'(pix_c) * PRW'(gain_cur);
    wire           prod_sat = |prod[PRW-1:ffgc_pkg::GAIN_FRAC+PW];
    wire [PW-1:0]  pix_gain = prod_sat ? {PW{1'b1}}
                              : prod[ffgc_pkg::GAIN_FRAC+PW-1:ffgc_pkg::GAIN_FRAC];
    wire [PW-1:0]  pix_out  = gain_en ? pix_gain : pix_c; // R10

    // ------------------------------------------------------------------
    // calibration collection and reduction
    // ------------------------------------------------------------------
    wire          col_now   = sens_valid && ((st == ffgc_pkg::S_CAL)
                              || (st == ffgc_pkg::S_ARM && idx == '0)); // R12
    wire          first_ln  = (st == ffgc_pkg::S_ARM) || (line_cnt == '0);
    wire          cal_last  = col_now && last_pix && (line_cnt == SW'(ffgc_pkg::CAL_LINES - 1));
    wire [PW-1:0] scan_avg  = acc[sidx][AW-1:SW]; // R6
    wire          scan_last = (sidx == LAST_IDX);
    wire          div_start = (st == ffgc_pkg::S_DIV);
    wire          line_idle = !sens_valid && (idx == '0);

    ffgc_div #(
        .W (GW)
    ) u_div (
        .hclk    (hclk),
        .hresetn (hresetn),
        .start   (div_start),
        .num     ({ref_avg, {ffgc_pkg::GAIN_FRAC{1'b0}}}),
        .den     (GW'(scan_avg)),
        .done    (div_done),
        .quot    (div_q)
    );

    always_comb
    begin
        next_st = st;
        unique case (st)
            ffgc_pkg::S_IDLE: if (gen_cmd) next_st = ffgc_pkg::S_ARM;
            ffgc_pkg::S_ARM:  if (col_now) next_st = ffgc_pkg::S_CAL;
            ffgc_pkg::S_CAL:  if (cal_last) next_st = ffgc_pkg::S_MAX; // R1
            ffgc_pkg::S_MAX:  if (scan_last) next_st = ffgc_pkg::S_DIV;
            ffgc_pkg::S_DIV:  next_st = ffgc_pkg::S_WAIT;
            ffgc_pkg::S_WAIT:
                if (div_done) next_st = scan_last ? ffgc_pkg::S_SWAP : ffgc_pkg::S_DIV;
            ffgc_pkg::S_SWAP: if (line_idle) next_st = ffgc_pkg::S_IDLE; // R17
            default:          next_st = ffgc_pkg::S_IDLE;
        endcase
    end

    // ------------------------------------------------------------------
    // memories, written without reset
    // ------------------------------------------------------------------
    always_ff @(posedge hclk)
    begin
        if (ofs_we)
            ofs_tab[ofs_addr] <= ofs_data;
        if (col_now)
            acc[idx] <= (first_ln ? AW'(0) : acc[idx]) + AW'(pix_c); // R6 R14
        if (st == ffgc_pkg::S_WAIT && div_done)
            gain_tab[~bank][sidx] <= div_q; // R8 R9
    end

    // ------------------------------------------------------------------
    // control state
    // ------------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            st        <= ffgc_pkg::S_IDLE;
            mode      <= ffgc_pkg::MODE_RESET;
            bank      <= 1'b0;
            tab_valid <= 1'b0;
            line_cnt  <= '0;
            sidx      <= '0;
            ref_avg   <= '0;
        end
        else
        begin
            st <= next_st;
            if (mode_cmd)
                mode <= lnk.cmd_data[ffgc_pkg::MODE_W-1:0]; // R13
            if (gen_cmd)
                line_cnt <= '0;
            else if (col_now && last_pix)
                line_cnt <= line_cnt + 1'b1;
            if (st == ffgc_pkg::S_CAL)
            begin
                sidx    <= '0;
                ref_avg <= '0;
            end
            else if (st == ffgc_pkg::S_MAX)
            begin
                sidx <= scan_last ? '0 : sidx + 1'b1;
                if (scan_avg > ref_avg)
                    ref_avg <= scan_avg; // R7
            end
            else if (st == ffgc_pkg::S_WAIT && div_done && !scan_last)
                sidx <= sidx + 1'b1;
            if (st == ffgc_pkg::S_SWAP && line_idle)
            begin
                bank      <= ~bank; // R17 R9
                tab_valid <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------------
    // line timing and video output; calibration does not gate the stream
    // ------------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            idx            <= '0;
            free_cnt       <= '0;
            capture_req    <= 1'b0;
            lnk.line_valid <= 1'b0;
            lnk.data_valid <= 1'b0;
            lnk.pix_data   <= '0;
        end
        else
        begin
            if (sens_valid)
                idx <= last_pix ? '0 : idx + 1'b1;
            free_cnt       <= (!free_run || free_tick) ? '0 : free_cnt + 1'b1;
            capture_req    <= trig_tick;
            lnk.data_valid <= sens_valid; // R3
            lnk.pix_data   <= sens_valid ? pix_out : '0;
            // stays high through gaps until the last pixel of the line has passed
            lnk.line_valid <= sens_valid || (idx != '0); // R3
        end
    end
endmodule

/* File: hw/ffgc_pkg.sv */
package ffgc_pkg;

    // ------------------------------------------------------------------
    // pixel and table formats
    // ------------------------------------------------------------------
    localparam int PIX_W        = 8;
    localparam int LINE_PIX_DEF = 16;
    localparam int CAL_LINES    = 16;
    localparam int CAL_SHIFT    = 4;
    localparam int ACC_W        = PIX_W + CAL_SHIFT;
    localparam int GAIN_FRAC    = 8;
    localparam int GAIN_W       = PIX_W + GAIN_FRAC;
    localparam logic [GAIN_W-1:0] GAIN_ONE = 16'h0100;

    // ------------------------------------------------------------------
    // command channel
    // ------------------------------------------------------------------
    localparam int   SEL_W = 2;
    localparam logic [SEL_W-1:0] SEL_MODE = 2'h0;
    localparam logic [SEL_W-1:0] SEL_GEN  = 2'h1;
    localparam int   CMD_W         = 8;
    localparam int   MODE_GAIN_BIT = 0;
    localparam int   MODE_OFS_BIT  = 1;
    localparam int   MODE_FREE_BIT = 2;
    localparam int   MODE_W        = 3;
    localparam int   GEN_BIT       = 0;
    localparam logic [MODE_W-1:0] MODE_RESET = 3'h0;

    // ------------------------------------------------------------------
    // timing
    // ------------------------------------------------------------------
    localparam int CLK_NS       = 100;
    localparam int FREE_RUN_NS  = 100000;
    localparam int FREE_RUN_CYC = FREE_RUN_NS / CLK_NS;

    // ------------------------------------------------------------------
    // host register map (AHB-Lite byte offsets)
    // ------------------------------------------------------------------
    localparam logic [7:0] A_CTRL = 8'h00;
    localparam logic [7:0] A_GEN  = 8'h04;
    localparam logic [7:0] A_TRIG = 8'h08;
    localparam logic [7:0] A_STAT = 8'h0C;
    localparam int   TRIG_W        = 16;
    localparam int   STAT_PEND_BIT = 0;
    localparam int   STAT_BUSY_BIT = 1;
    localparam logic [1:0] HTRANS_NONSEQ = 2'b10;

    typedef enum logic [2:0] {S_IDLE, S_ARM, S_CAL, S_MAX, S_DIV, S_WAIT, S_SWAP} ffgc_state_e;

endpackage

/* File: hw/ffgc_if.sv */
`timescale 1ns/10ps
interface ffgc_if;
    logic                                  cmd_valid;
    logic [ffgc_pkg::SEL_W-1:0]            cmd_sel;
    logic [ffgc_pkg::CMD_W-1:0]            cmd_data;
    logic                                  cmd_ack;
    logic                                  line_trig;
    logic                                  cal_busy;
    logic                                  line_valid;
    logic                                  data_valid;
    logic [ffgc_pkg::PIX_W-1:0]            pix_data;

    modport dev  (input cmd_valid, cmd_sel, cmd_data, line_trig,
                  output cmd_ack, cal_busy, line_valid, data_valid, pix_data);
    modport host (output cmd_valid, cmd_sel, cmd_data, line_trig,
                  input cmd_ack, cal_busy, line_valid, data_valid, pix_data);
endinterface

/* File: hw/ffgc_div.sv */
`timescale 1ns/10ps
// restoring divider, one quotient bit per clock; a zero divisor yields all ones
module ffgc_div #(
    parameter int W = 16
) (
    // clock and reset
    input  logic         hclk,
    input  logic         hresetn,
    // request
    input  logic         start,
    input  logic [W-1:0] num,
    input  logic [W-1:0] den,
    // answer
    output logic         done,
    output logic [W-1:0] quot
);
    localparam int CW = $clog2(W + 1);

    logic [W:0]    rem;
    logic [CW-1:0] cnt;
    logic          busy;
    wire  [W:0]    shifted = {rem[W-1:0], quot[W-1]};
    wire  [W:0]    diff    = shifted - {1'b0, den};

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            rem  <= '0;
            quot <= '0;
            cnt  <= '0;
            busy <= 1'b0;
            done <= 1'b0;
        end
        else if (start)
        begin
            rem  <= '0;
            quot <= num;
            cnt  <= CW'(W);
            busy <= 1'b1;
            done <= 1'b0;
        end
        else if (busy)
        begin
            rem  <= diff[W] ? shifted : diff;
            quot <= {quot[W-2:0], ~diff[W]};
            cnt  <= cnt - 1'b1;
            busy <= (cnt != CW'(1));
            done <= (cnt == CW'(1));
        end
        else
        begin
            done <= 1'b0;
        end
    end
endmodule

/* File: hw/ffgc_host.sv */
`timescale 1ns/10ps
module ffgc_host (
    // clock and reset
    input  logic        hclk,
    input  logic        hresetn,
    // AHB-Lite slave
    input  logic        hsel,
    input  logic [31:0] haddr,
    input  logic [1:0]  htrans,
    input  logic        hwrite,
    input  logic [2:0]  hsize,
    input  logic [31:0] hwdata,
    input  logic        hready,
    output logic        hreadyout,
    output logic [31:0] hrdata,
    output logic        hresp,
    // link to the camera
    ffgc_if.host        lnk
);
    localparam int TW = ffgc_pkg::TRIG_W;

    logic                        ap_valid;
    logic                        ap_write;
    logic [7:0]                  ap_addr;
    logic                        cmd_pend;
    logic [ffgc_pkg::MODE_W-1:0] ctrl;
    logic [TW-1:0]               trig_per;
    logic [TW-1:0]               trig_cnt;

    // ------------------------------------------------------------------
    // bus decode; a command write waits while the camera is busy
    // ------------------------------------------------------------------
    wire ap_take  = hready && hsel && (htrans == ffgc_pkg::HTRANS_NONSEQ);
    wire wr_ctrl  = ap_valid && ap_write && (ap_addr == ffgc_pkg::A_CTRL);
    wire wr_gen   = ap_valid && ap_write && (ap_addr == ffgc_pkg::A_GEN);
    wire wr_trig  = ap_valid && ap_write && (ap_addr == ffgc_pkg::A_TRIG);
    wire cmd_hold = (wr_ctrl || wr_gen) && (cmd_pend || lnk.cal_busy); // R5
    wire wr_cmd   = (wr_ctrl || wr_gen) && !cmd_hold;
    wire [7:0] rd_addr = haddr[7:0];
    wire [31:0] rd_val =
        (rd_addr == ffgc_pkg::A_CTRL) ? 32'(ctrl) :
        (rd_addr == ffgc_pkg::A_TRIG) ? 32'(trig_per) :
        (rd_addr == ffgc_pkg::A_STAT) ? 32'({lnk.cal_busy, cmd_pend}) : 32'h0000_0000;
    wire trig_hit = (trig_per != '0) && (trig_cnt == trig_per - 1'b1);

    assign hreadyout = !cmd_hold;
    assign hresp     = 1'b0;

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            ap_valid <= 1'b0;
            ap_write <= 1'b0;
            ap_addr  <= '0;
            hrdata   <= '0;
        end
        else if (hreadyout)
        begin
            ap_valid <= ap_take;
            ap_write <= hwrite;
            ap_addr  <= haddr[7:0];
            if (ap_take && !hwrite)
                hrdata <= rd_val;
        end
    end

    // ------------------------------------------------------------------
    // command channel: one outstanding command, held until acknowledged
    // ------------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            cmd_pend     <= 1'b0;
            lnk.cmd_sel  <= '0;
            lnk.cmd_data <= '0;
            ctrl         <= ffgc_pkg::MODE_RESET;
        end
        else if (wr_cmd)
        begin
            cmd_pend     <= 1'b1;
            lnk.cmd_sel  <= wr_gen ? ffgc_pkg::SEL_GEN : ffgc_pkg::SEL_MODE; // R12 R13
            lnk.cmd_data <= hwdata[ffgc_pkg::CMD_W-1:0];
            if (wr_ctrl)
                ctrl <= hwdata[ffgc_pkg::MODE_W-1:0];
        end
        else if (lnk.cmd_ack)
            cmd_pend <= 1'b0;
    end

    assign lnk.cmd_valid = cmd_pend;

    // ------------------------------------------------------------------
    // line trigger generator; period zero stops it
    // ------------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            trig_per      <= '0;
            trig_cnt      <= '0;
            lnk.line_trig <= 1'b0;
        end
        else
        begin
            if (wr_trig)
                trig_per <= hwdata[TW-1:0];
            trig_cnt      <= (trig_hit || trig_per == '0) ? '0 : trig_cnt + 1'b1;
            lnk.line_trig <= trig_hit; // R2
        end
    end
endmodule

/* File: bench/ffgc_assertions.sv */
`timescale 1ns/10ps
module ffgc_assertions (
    // clock and reset
    input logic                       hclk,
    input logic                       hresetn,
    // command link
    input logic                       cmd_valid,
    input logic [ffgc_pkg::SEL_W-1:0] cmd_sel,
    input logic [ffgc_pkg::CMD_W-1:0] cmd_data,
    input logic                       cmd_ack,
    input logic                       line_trig,
    input logic                       cal_busy,
    // pixel stream
    input logic                       line_valid,
    input logic                       data_valid,
    input logic [ffgc_pkg::PIX_W-1:0] pix_data
);
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    // ----
    // link sequences
    // ----
    sequence gen_taken;
        cmd_valid && cmd_ack && cmd_sel == ffgc_pkg::SEL_GEN && cmd_data[ffgc_pkg::GEN_BIT];
    endsequence

    // ----
    // lines leaving the device while calibration runs
    // ----
    logic       lv_q;
    logic [4:0] busy_lines;

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            lv_q       <= 1'b0;
            busy_lines <= '0;
        end
        else
        begin
            lv_q <= line_valid;
            if (!cal_busy)
                busy_lines <= '0;
            else if (lv_q && !line_valid && busy_lines != 5'h1F)
                busy_lines <= busy_lines + 5'h01;
        end
    end

    AST_NO_ACK_BUSY: assert property (cal_busy |-> !cmd_ack)
        else $error("command acknowledged during calibration");
    AST_GEN_START: assert property (gen_taken |=> cal_busy)
        else $error("generate taken but calibration not started");
    AST_BUSY_LONG: assert property ($rose(cal_busy) |-> cal_busy [*8])
        else $error("calibration ended too early");
    AST_CMD_HOLD: assert property (cmd_valid |=> (cmd_valid || $past(cmd_ack))
                                   && $stable(cmd_sel) && $stable(cmd_data))
        else $error("pending command changed before acknowledge");
    AST_CAL_LINES: assert property ($fell(cal_busy) |-> busy_lines >= 5'(ffgc_pkg::CAL_LINES))
        else $error("calibration ended before sixteen lines passed");
    AST_CMD_ONE: assert property (cmd_valid && cmd_ack |=> !cmd_valid)
        else $error("command stayed pending after acknowledge");
    AST_DV_IN_LINE: assert property (data_valid |-> line_valid)
        else $error("pixel outside line valid");
    AST_PIX_IDLE: assert property (!data_valid |-> pix_data == '0)
        else $error("pixel data not zero when idle");
    AST_TRIG_PULSE: assert property (line_trig |=> !line_trig)
        else $error("line trigger longer than one cycle");
endmodule

/* File: bench/flat_field_gain_correction_tb_top.sv */
`timescale 1ns/10ps
module flat_field_gain_correction_tb_top;
    localparam int NP   = 16;
    localparam int TRIG = 60;

    logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp;
    logic        capture_req, sens_valid, ofs_we;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [7:0]  sens_data, ofs_data;
    logic [3:0]  ofs_addr;
    logic [7:0]  line_buf[NP], cur[NP], got[NP], ofs[NP], cal[NP];
    logic [15:0] egain[NP];
    int          err_count, samples_checked;

    ffgc_if lnk ();
    ffgc_host i_ffgc_host (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .lnk(lnk.host));
    ffgc_device #(.LINE_PIX(NP), .FREE_CYC(TRIG)) i_ffgc_device (.hclk(hclk),
        .hresetn(hresetn), .lnk(lnk.dev), .capture_req(capture_req), .sens_valid(sens_valid),
        .sens_data(sens_data), .ofs_we(ofs_we), .ofs_addr(ofs_addr), .ofs_data(ofs_data));
    ffgc_assertions i_ffgc_assertions (.hclk(hclk), .hresetn(hresetn),
        .cmd_valid(lnk.cmd_valid), .cmd_sel(lnk.cmd_sel), .cmd_data(lnk.cmd_data),
        .cmd_ack(lnk.cmd_ack), .line_trig(lnk.line_trig), .cal_busy(lnk.cal_busy),
        .line_valid(lnk.line_valid), .data_valid(lnk.data_valid), .pix_data(lnk.pix_data));

    always #50 hclk = ~hclk;

    // ----
    // sensor: one whole line per capture request, random one-cycle gaps
    // ----
    always
    begin
        @(negedge hclk);
        if (capture_req === 1'b1)
        begin
            cur = line_buf;
            @(posedge hclk);
            foreach (cur[i])
            begin
                sens_valid <= 1'b1;
                sens_data  <= cur[i];
                @(posedge hclk);
                if ($urandom_range(3) == 0)
                begin
                    sens_valid <= 1'b0;
                    @(posedge hclk);
                end
            end
            sens_valid <= 1'b0;
        end
    end

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic stop_test;
        if (err_count == 0 && samples_checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // hready is sampled at the falling edge: it only moves after a rising edge
    task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        htrans <= ffgc_pkg::HTRANS_NONSEQ;
        haddr  <= {24'h000000, a};
        hwrite <= wr;
        do @(negedge hclk); while (hreadyout !== 1'b1);
        @(posedge hclk);
        htrans <= 2'h0;
        hwdata <= wd;
        do @(negedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
        @(posedge hclk);
    endtask

    task automatic rd_chk(input string name, input logic [7:0] a, input logic [31:0] exp);
        ahb(1'b0, a, 32'h0);
        check(name, rd, exp);
    endtask

    // skips a line so a mode or buffer change is surely in effect
    task automatic grab;
        int n;
        n = 0;
        @(negedge hclk);
        repeat (2)
        begin
            while (lnk.line_valid !== 1'b0) @(negedge hclk);
            while (lnk.line_valid !== 1'b1) @(negedge hclk);
        end
        while (n < NP)
        begin
            if (lnk.data_valid === 1'b1)
            begin
                got[n] = lnk.pix_data;
                n++;
            end
            @(negedge hclk);
        end
        @(posedge hclk);
    endtask

    function automatic logic [7:0] exp_pix(input int i, input bit g, input bit o);
        int v;
        v = line_buf[i];
        if (o) v = v + ofs[i];
        if (v > 255) v = 255;
        if (g) v = (v * egain[i]) >> 8;
        return (v > 255) ? 8'hFF : 8'(v);
    endfunction

    function automatic void calc(input bit o);
        int a[NP];
        int r;
        r = 0;
        foreach (a[i])
        begin
            a[i] = o ? cal[i] + ofs[i] : cal[i];
            if (a[i] > 255) a[i] = 255;
            if (a[i] > r) r = a[i];
        end
        foreach (a[i]) egain[i] = (a[i] == 0) ? 16'hFFFF : 16'((r * 256) / a[i]);
    endfunction

    task automatic run_line(input bit g, input bit o);
        foreach (line_buf[i]) line_buf[i] = 8'($urandom);
        line_buf[0] = 8'hFF;
        grab();
        foreach (got[i]) check("pixel", got[i], exp_pix(i, g, o));
    endtask

    initial
    begin
        repeat (50000) @(posedge hclk);
        err_count++;
        stop_test();
    end

    initial
    begin
        {hclk, hresetn, htrans, haddr, hwrite, hwdata} = '0;
        {sens_valid, sens_data, ofs_we, ofs_addr, ofs_data} = '0;
        hsel = 1'b1;
        hsize = 3'h2;
        err_count = 0;
        samples_checked = 0;
        foreach (egain[i]) egain[i] = ffgc_pkg::GAIN_ONE;
        foreach (line_buf[i]) line_buf[i] = 8'h00;
        void'($urandom(32'h34B7));
        repeat (8) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        rd_chk("ctrl at reset", ffgc_pkg::A_CTRL, 32'(ffgc_pkg::MODE_RESET));
        rd_chk("unmapped", 8'h10, 32'h0);
        ahb(1'b1, ffgc_pkg::A_TRIG, TRIG);
        rd_chk("trigger period", ffgc_pkg::A_TRIG, TRIG);
        ahb(1'b1, ffgc_pkg::A_CTRL, 32'h1);
        rd_chk("ctrl readback", ffgc_pkg::A_CTRL, 32'h1);
        run_line(1'b1, 1'b0);
        foreach (ofs[i])
        begin
            ofs[i] = 8'($urandom_range(15));
            ofs_we   <= 1'b1;
            ofs_addr <= 4'(i);
            ofs_data <= ofs[i];
            @(posedge hclk);
        end
        ofs_we <= 1'b0;
        // first pass on external triggers, second free-running with offsets
        for (int k = 0; k < 2; k++)
        begin
            foreach (cal[i]) cal[i] = 8'($urandom_range(239, 128));
            line_buf = cal;
            if (k == 1) ahb(1'b1, ffgc_pkg::A_TRIG, 32'h0);
            ahb(1'b1, ffgc_pkg::A_CTRL, k ? 32'h6 : 32'h0);
            ahb(1'b1, ffgc_pkg::A_GEN, 32'h1);
            grab();
            rd_chk("busy status", ffgc_pkg::A_STAT, 32'h2);
            ahb(1'b1, ffgc_pkg::A_CTRL, k ? 32'h7 : 32'h1);
            check("busy after held write", 32'(lnk.cal_busy), 32'h0);
            calc(k);
            run_line(1'b1, k);
        end
        ahb(1'b1, ffgc_pkg::A_CTRL, 32'h6);
        run_line(1'b0, 1'b1);
        ahb(1'b1, ffgc_pkg::A_CTRL, 32'h0);
        repeat (100) @(posedge hclk);
        hresetn <= 1'b0;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        foreach (egain[i]) egain[i] = ffgc_pkg::GAIN_ONE;
        rd_chk("ctrl after reset", ffgc_pkg::A_CTRL, 32'h0);
        ahb(1'b1, ffgc_pkg::A_TRIG, TRIG);
        ahb(1'b1, ffgc_pkg::A_CTRL, 32'h1);
        run_line(1'b1, 1'b0);
        stop_test();
    end
endmodule
